/* File: common/overlay_pkg.sv */
/*
 Constants, register map and the geometry carrier for the overlay window register bank.
 Assumes byte-wide registers at byte offsets on a plain strobe port.
*/
package overlay_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_SHADOW = 13;

    // Register byte offsets
    localparam logic [7:0] OFS_W1_ADDR_LOW = 8'h2C;
    localparam logic [7:0] OFS_W1_ADDR_MID = 8'h2E;
    localparam logic [7:0] OFS_W1_ADDR_HIGH = 8'h30;
    localparam logic [7:0] OFS_W1_X_START = 8'h32;
    localparam logic [7:0] OFS_W1_Y_START_HIGH = 8'h34;
    localparam logic [7:0] OFS_W1_Y_START_LOW = 8'h36;
    localparam logic [7:0] OFS_W1_X_END = 8'h38;
    localparam logic [7:0] OFS_W1_Y_END_HIGH = 8'h3A;
    localparam logic [7:0] OFS_W1_Y_END_LOW = 8'h3C;
    localparam logic [7:0] OFS_W2_ADDR_LOW = 8'h3E;
    localparam logic [7:0] OFS_W2_ADDR_MID = 8'h40;
    localparam logic [7:0] OFS_W2_ADDR_HIGH = 8'h42;
    localparam logic [7:0] OFS_W2_X_START = 8'h44;
    localparam logic [7:0] OFS_COMMIT = 8'h50;
    localparam int COMMIT_BIT = 7;

    // Shadow array indices
    localparam int IDX_W1_ADDR_LOW = 0;
    localparam int IDX_W1_ADDR_MID = 1;
    localparam int IDX_W1_ADDR_HIGH = 2;
    localparam int IDX_W1_X_START = 3;
    localparam int IDX_W1_Y_START_HIGH = 4;
    localparam int IDX_W1_Y_START_LOW = 5;
    localparam int IDX_W1_X_END = 6;
    localparam int IDX_W1_Y_END_HIGH = 7;
    localparam int IDX_W1_Y_END_LOW = 8;
    localparam int IDX_W2_ADDR_LOW = 9;
    localparam int IDX_W2_ADDR_MID = 10;
    localparam int IDX_W2_ADDR_HIGH = 11;
    localparam int IDX_W2_X_START = 12;

    localparam logic [7:0] SHADOW_OFS [NUM_SHADOW] = '{
        8'h2C, 8'h2E, 8'h30, 8'h32, 8'h34, 8'h36, 8'h38,
        8'h3A, 8'h3C, 8'h3E, 8'h40, 8'h42, 8'h44};
    // Implemented bits per register; the rest read as zero
    localparam logic [7:0] SHADOW_MASK [NUM_SHADOW] = '{
        8'hF8, 8'hFF, 8'hFF, 8'hFE, 8'hFF, 8'h03, 8'hFE,
        8'hFF, 8'h03, 8'hF8, 8'hFF, 8'hFF, 8'hFE};
    localparam logic [7:0] SHADOW_RESET = 8'h00;

    // Output select codes that show a window
    localparam logic [2:0] SEL_WIN1 = 3'h2;
    localparam logic [2:0] SEL_WIN2 = 3'h3;
    localparam logic [2:0] SEL_BOTH = 3'h4;

    typedef struct packed {
        logic [23:0] win1_addr;
        logic [9:0] win1_x_start;
        logic [9:0] win1_x_end;
        logic [10:0] win1_y_start;
        logic [10:0] win1_y_end;
        logic [23:0] win2_addr;
        logic [9:0] win2_x_start;
    } geometry_t;

    // Effective geometry of all-zero registers
    localparam geometry_t GEOM_RESET = '{
        win1_addr: 24'h000000,
        win1_x_start: 10'h001,
        win1_x_end: 10'h001,
        win1_y_start: 11'h001,
        win1_y_end: 11'h001,
        win2_addr: 24'h000000,
        win2_x_start: 10'h001};
endpackage

/* File: core/overlay_window_geometry_regs.sv */
/*
 Shadowed geometry registers of two overlay windows, loaded into working
 registers on a commit write. Assumes a plain byte register port that
 never waits, one strobe per cycle, and an output select from the display
 mode logic that is synchronous to clk.
*/
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module overlay_window_geometry_regs (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Register port
    input wire logic [overlay_pkg::ADDR_W-1:0] addr,
    input wire logic [overlay_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [overlay_pkg::DATA_W-1:0] rdata,
    // Display mode output select
    input wire logic [2:0] display_select,
    // Working geometry towards the display pipeline
    output overlay_pkg::geometry_t geometry,
    output logic win1_enable,
    output logic win2_enable
);
    import overlay_pkg::*;

    logic [DATA_W-1:0] shadow_q [NUM_SHADOW];
    geometry_t geom_q;
    geometry_t geom_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic win1_en_q;
    logic win2_en_q;
    logic [NUM_SHADOW-1:0] sel_vec;
    logic [DATA_W-1:0] rd_terms [NUM_SHADOW];
    logic commit_wr;
    logic win1_shown;
    logic win2_shown;
    logic any_hit;

    function automatic logic ofs_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        ofs_hit = (a == ofs);
    endfunction

    // X encoding: byte x4 plus 1, bit 0 already forced to zero
    function automatic logic [9:0] x_eff(input logic [7:0] v);
        x_eff = {v, 2'b01};
    endfunction

    function automatic logic [10:0] y_eff(input logic [7:0] hi, input logic [7:0] lo);
        y_eff = {1'b0, hi, lo[1:0]} + 11'h001;
    endfunction

    // Register decode
    generate
        for (genvar i = 0; i < NUM_SHADOW; i++) begin : g_shadow
            assign sel_vec[i] = ofs_hit(addr, SHADOW_OFS[i]);
            assign rd_terms[i] = sel_vec[i] ? shadow_q[i] : 8'h00;

            // Shadow only; working copy untouched until commit
            always_ff @(posedge clk) begin
                if (srst) begin
                    shadow_q[i] <= SHADOW_RESET;
                end else if (ce && wr && sel_vec[i]) begin
                    shadow_q[i] <= wdata & SHADOW_MASK[i];
                end
            end

            property p_shadow_load;
                @(posedge clk) disable iff (srst)
                (ce && wr && sel_vec[i]) |=> (shadow_q[i] == ($past(wdata) & SHADOW_MASK[i]));
            endproperty
            a_shadow_load: assert property (p_shadow_load)
                else $error("shadow did not take the masked write data");

            property p_shadow_hold;
                @(posedge clk) disable iff (srst)
                !(ce && wr && sel_vec[i]) |=> $stable(shadow_q[i]);
            endproperty
            a_shadow_hold: assert property (p_shadow_hold)
                else $error("shadow changed without a write to it");

            property p_read_shadow;
                @(posedge clk) disable iff (srst)
                (ce && rd && sel_vec[i]) |=> (rdata == $past(shadow_q[i]));
            endproperty
            a_read_shadow: assert property (p_read_shadow)
                else $error("read data differ from the shadow");
        end
    endgenerate

    assign commit_wr = wr && ofs_hit(addr, OFS_COMMIT) && wdata[COMMIT_BIT];
    assign any_hit = |sel_vec;

    // Commit bit is self-clearing, so the commit offset and unmapped offsets read zero
    always_comb begin
        rdata_d = 8'h00;
        for (int i = 0; i < NUM_SHADOW; i++) begin
            rdata_d = rdata_d | rd_terms[i];
        end
    end

    // Effective geometry from the shadows
    always_comb begin
        geom_d = geom_q;
        geom_d.win1_addr = {shadow_q[IDX_W1_ADDR_HIGH], shadow_q[IDX_W1_ADDR_MID],
            shadow_q[IDX_W1_ADDR_LOW][7:3], 3'b000};
        geom_d.win1_x_start = x_eff(shadow_q[IDX_W1_X_START]);
        geom_d.win1_x_end = x_eff(shadow_q[IDX_W1_X_END]);
        geom_d.win1_y_start = y_eff(shadow_q[IDX_W1_Y_START_HIGH],
            shadow_q[IDX_W1_Y_START_LOW]);
        geom_d.win1_y_end = y_eff(shadow_q[IDX_W1_Y_END_HIGH],
            shadow_q[IDX_W1_Y_END_LOW]);
        geom_d.win2_addr = {shadow_q[IDX_W2_ADDR_HIGH], shadow_q[IDX_W2_ADDR_MID],
            shadow_q[IDX_W2_ADDR_LOW][7:3], 3'b000};
        geom_d.win2_x_start = x_eff(shadow_q[IDX_W2_X_START]);
    end

    // Select is not tied to commit; it may change while the panel runs
    assign win1_shown = (display_select == SEL_WIN1) || (display_select == SEL_BOTH);
    assign win2_shown = (display_select == SEL_WIN2) || (display_select == SEL_BOTH);

    always_ff @(posedge clk) begin
        if (srst) begin
            geom_q <= GEOM_RESET;
        end else if (ce && commit_wr) begin
            geom_q <= geom_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else if (ce) begin
            rdata_q <= rd ? rdata_d : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            win1_en_q <= 1'b0;
            win2_en_q <= 1'b0;
        end else if (ce) begin
            win1_en_q <= win1_shown;
            win2_en_q <= win2_shown;
        end
    end

    // Panel bounds are software's duty, so the geometry passes unclamped
    assign geometry = geom_q;
    assign win1_enable = win1_en_q;
    assign win2_enable = win2_en_q;
    assign rdata = rdata_q;

    // Checks

    property p_w1_x_start;
        @(posedge clk) disable iff (srst)
        (ce && commit_wr) |=> (geom_q.win1_x_start == {$past(shadow_q[IDX_W1_X_START]), 2'b01});
    endproperty
    a_w1_x_start: assert property (p_w1_x_start)
        else $error("first window x start not byte x4 plus 1");

    property p_hold_until_commit;
        @(posedge clk) disable iff (srst)
        !(ce && commit_wr) |=> $stable(geom_q);
    endproperty
    a_hold_until_commit: assert property (p_hold_until_commit)
        else $error("working geometry changed without commit");

    property p_shadow_write_no_effect;
        @(posedge clk) disable iff (srst)
        (ce && wr && sel_vec[IDX_W1_X_START] && !commit_wr) ##1 (!(ce && commit_wr))
        |=> (geom_q == $past(geom_q, 2));
    endproperty
    a_shadow_write_no_effect: assert property (p_shadow_write_no_effect)
        else $error("shadow write reached working geometry");

    property p_x_step;
        @(posedge clk) disable iff (srst)
        1'b1 |-> (geom_q.win1_x_start[2:0] == 3'b001) && (geom_q.win1_x_end[2:0] == 3'b001)
            && (geom_q.win2_x_start[2:0] == 3'b001);
    endproperty
    a_x_step: assert property (p_x_step)
        else $error("x position off the 8 pixel grid");

    property p_w1_y_start;
        @(posedge clk) disable iff (srst)
        (ce && commit_wr) |=> (geom_q.win1_y_start == ({1'b0,
            $past(shadow_q[IDX_W1_Y_START_HIGH]), $past(shadow_q[IDX_W1_Y_START_LOW][1:0])}
            + 11'h001));
    endproperty
    a_w1_y_start: assert property (p_w1_y_start)
        else $error("first window y start wrong");

    property p_w1_y_end;
        @(posedge clk) disable iff (srst)
        (ce && commit_wr) |=> (geom_q.win1_y_end == ({1'b0,
            $past(shadow_q[IDX_W1_Y_END_HIGH]), $past(shadow_q[IDX_W1_Y_END_LOW][1:0])}
            + 11'h001));
    endproperty
    a_w1_y_end: assert property (p_w1_y_end)
        else $error("first window y end wrong");

    property p_w2_addr;
        @(posedge clk) disable iff (srst)
        (ce && commit_wr) |=> (geom_q.win2_addr == {$past(shadow_q[IDX_W2_ADDR_HIGH]),
            $past(shadow_q[IDX_W2_ADDR_MID]), $past(shadow_q[IDX_W2_ADDR_LOW][7:3]), 3'b000});
    endproperty
    a_w2_addr: assert property (p_w2_addr)
        else $error("second window start address wrong");

    property p_w2_x_start;
        @(posedge clk) disable iff (srst)
        (ce && commit_wr) |=> (geom_q.win2_x_start == {$past(shadow_q[IDX_W2_X_START]), 2'b01});
    endproperty
    a_w2_x_start: assert property (p_w2_x_start)
        else $error("second window x start wrong");

    property p_w1_x_end_bit0;
        @(posedge clk) disable iff (srst)
        (ce && rd && sel_vec[IDX_W1_X_END]) |=> (rdata[0] == 1'b0);
    endproperty
    a_w1_x_end_bit0: assert property (p_w1_x_end_bit0)
        else $error("unused x end bit 0 reads as one");

    property p_w1_x_end;
        @(posedge clk) disable iff (srst)
        (ce && wr && sel_vec[IDX_W1_X_END]) ##1 (ce && commit_wr)
        |=> (geom_q.win1_x_end == {$past(wdata[7:1], 2), 3'b001});
    endproperty
    a_w1_x_end: assert property (p_w1_x_end)
        else $error("first window x end wrong after write and commit");

    property p_win1_enable;
        @(posedge clk) disable iff (srst)
        ce |=> (win1_enable == (($past(display_select) == SEL_WIN1)
            || ($past(display_select) == SEL_BOTH)));
    endproperty
    a_win1_enable: assert property (p_win1_enable)
        else $error("first window enable disagrees with select");

    property p_win2_enable;
        @(posedge clk) disable iff (srst)
        ce |=> (win2_enable == (($past(display_select) == SEL_WIN2)
            || ($past(display_select) == SEL_BOTH)));
    endproperty
    a_win2_enable: assert property (p_win2_enable)
        else $error("second window enable disagrees with select");

    property p_w1_addr;
        @(posedge clk) disable iff (srst)
        (ce && commit_wr) |=> (geom_q.win1_addr == {$past(shadow_q[IDX_W1_ADDR_HIGH]),
            $past(shadow_q[IDX_W1_ADDR_MID]), $past(shadow_q[IDX_W1_ADDR_LOW][7:3]), 3'b000});
    endproperty
    a_w1_addr: assert property (p_w1_addr)
        else $error("first window start address wrong");

    property p_readback;
        @(posedge clk) disable iff (srst)
        (ce && wr && sel_vec[IDX_W1_Y_START_LOW]) ##1 (ce && rd && sel_vec[IDX_W1_Y_START_LOW])
        |=> (rdata == {6'h00, $past(wdata[1:0], 2)});
    endproperty
    a_readback: assert property (p_readback)
        else $error("shadow readback differs from written value");

    property p_commit_reads_zero;
        @(posedge clk) disable iff (srst)
        (ce && rd && ofs_hit(addr, OFS_COMMIT)) |=> (rdata == 8'h00);
    endproperty
    a_commit_reads_zero: assert property (p_commit_reads_zero)
        else $error("commit register did not read zero");

    property p_freeze;
        @(posedge clk) disable iff (srst)
        !ce |=> ($stable(rdata) && $stable(geom_q) && $stable(win1_enable)
            && $stable(win2_enable));
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    // Reset acts even with clock enable low
    property p_reset_state;
        @(posedge clk)
        srst |=> ((geom_q == GEOM_RESET) && (rdata == 8'h00) && !win1_enable && !win2_enable);
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("state after reset differs from its reset value");

    property p_rdata_idle;
        @(posedge clk) disable iff (srst)
        (ce && !rd) |=> (rdata == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data stood longer than one cycle");

    property p_unmapped_read;
        @(posedge clk) disable iff (srst)
        (ce && rd && !any_hit) |=> (rdata == 8'h00);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped offset read as nonzero");

    property p_commit_bit_clear;
        @(posedge clk) disable iff (srst)
        (ce && wr && ofs_hit(addr, OFS_COMMIT) && !wdata[COMMIT_BIT]) |=> $stable(geom_q);
    endproperty
    a_commit_bit_clear: assert property (p_commit_bit_clear)
        else $error("commit write with bit 7 clear moved the geometry");

    property p_addr_align;
        @(posedge clk) disable iff (srst)
        1'b1 |-> (geom_q.win1_addr[2:0] == 3'b000) && (geom_q.win2_addr[2:0] == 3'b000);
    endproperty
    a_addr_align: assert property (p_addr_align)
        else $error("window start address not on an 8 byte boundary");

    property p_y_range;
        @(posedge clk) disable iff (srst)
        1'b1 |-> (geom_q.win1_y_start != 11'h000) && (geom_q.win1_y_end != 11'h000)
            && (geom_q.win1_y_start <= 11'h400) && (geom_q.win1_y_end <= 11'h400);
    endproperty
    a_y_range: assert property (p_y_range)
        else $error("y position outside 1 to 1024");

    property p_select_off;
        @(posedge clk) disable iff (srst)
        (ce && ((display_select < SEL_WIN1) || (display_select > SEL_BOTH)))
        |=> (!win1_enable && !win2_enable);
    endproperty
    a_select_off: assert property (p_select_off)
        else $error("window enabled by a select that shows no window");

    property p_win_both;
        @(posedge clk) disable iff (srst)
        (ce && (display_select == SEL_BOTH)) |=> (win1_enable && win2_enable);
    endproperty
    a_win_both: assert property (p_win_both)
        else $error("combined select did not enable both windows");
endmodule

/* File: tb/overlay_window_geometry_regs_tb_top.sv */
/*
 Self-checking bench for the overlay window geometry register bank.
 Assumes the design package and a single 250 MHz clock; the bench is the bus master.
*/
`timescale 1ns/1ps
module overlay_window_geometry_regs_tb_top;
    import overlay_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] display_select = 3'h0;
    logic [7:0] rdata;
    geometry_t geometry;
    logic win1_enable;
    logic win2_enable;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] sh [NUM_SHADOW];

    always #2 clk = ~clk;

    overlay_window_geometry_regs overlay_window_geometry_regs_i (
        .clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .display_select(display_select), .geometry(geometry),
        .win1_enable(win1_enable), .win2_enable(win2_enable));

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_geom(input geometry_t got, input geometry_t exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    function automatic geometry_t expect_geom();
        geometry_t g;
        g.win1_addr = {sh[2], sh[1], sh[0][7:3], 3'b000};
        g.win1_x_start = {sh[3][7:1], 1'b0, 2'b01};
        g.win1_x_end = {sh[6][7:1], 1'b0, 2'b01};
        g.win1_y_start = {1'b0, sh[4], sh[5][1:0]} + 11'h001;
        g.win1_y_end = {1'b0, sh[7], sh[8][1:0]} + 11'h001;
        g.win2_addr = {sh[11], sh[10], sh[9][7:3], 3'b000};
        g.win2_x_start = {sh[12][7:1], 1'b0, 2'b01};
        return g;
    endfunction

    task automatic t_reset();
        logic [7:0] d;
        for (int i = 0; i < NUM_SHADOW; i++) begin
            reg_rd(SHADOW_OFS[i], d);
            cmp8(d, SHADOW_RESET);
        end
        cmp_geom(geometry, GEOM_RESET);
        cmp8({6'h00, win2_enable, win1_enable}, 8'h00);
        $display("reset values done");
    endtask

    task automatic t_shadow();
        logic [7:0] d;
        for (int i = 0; i < NUM_SHADOW; i++) reg_wr(SHADOW_OFS[i], 8'hFF);
        for (int i = 0; i < NUM_SHADOW; i++) begin
            reg_rd(SHADOW_OFS[i], d);
            cmp8(d, SHADOW_MASK[i]);
            repeat (2) @(negedge clk);
            cmp8(rdata, 8'h00);
        end
        cmp_geom(geometry, GEOM_RESET);
        reg_wr(OFS_COMMIT, 8'h7F);
        @(negedge clk);
        cmp_geom(geometry, GEOM_RESET);
        reg_rd(8'h00, d);
        cmp8(d, 8'h00);
        reg_rd(OFS_COMMIT, d);
        cmp8(d, 8'h00);
        // All-ones boundary: Y reaches 0x400 and addresses their top
        for (int i = 0; i < NUM_SHADOW; i++) sh[i] = SHADOW_MASK[i];
        reg_wr(OFS_COMMIT, 8'h80);
        @(negedge clk);
        cmp_geom(geometry, expect_geom());
        $display("shadow and boundary commit done");
    endtask

    task automatic t_commit();
        geometry_t prev;
        prev = expect_geom();
        for (int i = 0; i < NUM_SHADOW; i++) begin
            sh[i] = (8'h5A + 8'(i * 19)) & SHADOW_MASK[i];
            reg_wr(SHADOW_OFS[i], 8'h5A + 8'(i * 19));
        end
        @(negedge clk);
        cmp_geom(geometry, prev);
        reg_wr(OFS_COMMIT, 8'h80);
        @(negedge clk);
        cmp_geom(geometry, expect_geom());
        // Steps of 8 pixels from the first position
        for (int k = 0; k < 4; k++) begin
            reg_wr(OFS_W1_X_START, 8'(2 * k));
            reg_wr(OFS_W2_X_START, 8'(2 * k + 1));
            reg_wr(OFS_COMMIT, 8'hFF);
            @(negedge clk);
            cmp8(geometry.win1_x_start[7:0], 8'(1 + 8 * k));
            cmp8(geometry.win2_x_start[7:0], 8'(1 + 8 * k));
        end
        $display("commit done");
    endtask

    task automatic t_select();
        for (int s = 0; s < 8; s++) begin
            @(posedge clk);
            display_select <= 3'(s);
            repeat (2) @(posedge clk);
            #1 cmp8({6'h00, win2_enable, win1_enable},
                    {6'h00, 1'(s == 3 || s == 4), 1'(s == 2 || s == 4)});
        end
        $display("output select done");
    endtask

    task automatic t_hold();
        logic [7:0] d;
        @(posedge clk);
        ce <= 1'b0;
        reg_wr(OFS_W1_X_END, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        reg_rd(OFS_W1_X_END, d);
        cmp8(d, sh[6]);
        $display("clock enable hold done");
    endtask

    // Write, commit, write and read with no idle cycle between strobes
    task automatic t_b2b();
        @(posedge clk);
        addr <= OFS_W1_X_END;
        wdata <= 8'h37;
        wr <= 1'b1;
        @(posedge clk);
        addr <= OFS_COMMIT;
        wdata <= 8'h80;
        @(posedge clk);
        addr <= OFS_W1_Y_START_LOW;
        wdata <= 8'hFE;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp8(rdata, 8'h02);
        cmp8(geometry.win1_x_end[7:0], 8'hD9);
        cmp8({6'h00, geometry.win1_x_end[9:8]}, 8'h00);
        $display("back to back strobes done");
    endtask

    // Reset in mid-run with clock enable low; reset must still act
    task automatic t_rst_mid();
        logic [7:0] d;
        @(posedge clk);
        srst <= 1'b1;
        ce <= 1'b0;
        @(posedge clk);
        srst <= 1'b0;
        ce <= 1'b1;
        @(negedge clk);
        cmp_geom(geometry, GEOM_RESET);
        cmp8({6'h00, win2_enable, win1_enable}, 8'h00);
        reg_rd(OFS_W1_X_END, d);
        cmp8(d, SHADOW_RESET);
        $display("mid-run reset done");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_shadow();
        t_commit();
        t_select();
        t_hold();
        t_b2b();
        t_rst_mid();
        test_done();
    end
endmodule
